// ### include/rsss_link_if.sv
// interface: isolated lines between host controller and front-end sequencer
`timescale 1ns/1ps
interface rsss_link_if;
  logic [2:0] range_code;    // host range selection
  logic       range_load;    // pulse: take range/function/filter/test
  logic       func_dc;       // DC function selected
  logic       filter_sel;    // filter option
  logic       test_sel;      // self-test selected
  logic [7:0] bias_data;     // bias-compensation code
  logic       bias_load;     // pulse: latch bias code
  logic [2:0] mux_sel;       // multiplexer select lines a,b,c

  modport host (
    output range_code, range_load, func_dc, filter_sel, test_sel,
    output bias_data, bias_load, mux_sel
  );
  modport device (
    input range_code, range_load, func_dc, filter_sel, test_sel,
    input bias_data, bias_load, mux_sel
  );
endinterface

// ### include/rsss_pkg.sv
// package: range codes, switch patterns, multiplexer codes and timing for the range/slope sequencer
package rsss_pkg;

  // range selection codes
  typedef enum logic [2:0] {
    RANGE_100MV,
    RANGE_1V,
    RANGE_10V,
    RANGE_100V,
    RANGE_1000V
  } rsss_range_type;

  // function selection
  typedef enum logic [1:0] {
    FUNC_DC,
    FUNC_OTHER
  } rsss_func_type;

  // switch pattern bit positions
  localparam int SW_HIGH_GAIN = 0;
  localparam int SW_ATTEN_OUT = 1;
  localparam int SW_DIRECT    = 2;
  localparam int SW_UNITY     = 3;
  localparam int SW_LOW_GAIN  = 4;
  localparam int SW_PROTECT   = 5;
  localparam int SW_WIDTH     = 6;

  // switch patterns {protect, low, unity, direct, atten, high}
  localparam logic [5:0] PAT_100MV = 6'h25;
  localparam logic [5:0] PAT_1V    = 6'h34;
  localparam logic [5:0] PAT_10V   = 6'h2A;
  localparam logic [5:0] PAT_100V  = 6'h14;
  localparam logic [5:0] PAT_1000V = 6'h0A;
  localparam logic [5:0] PAT_RESET = 6'h0A;

  // multiplexer select codes {a,b,c}
  localparam logic [2:0] MUX_RESET    = 3'h7;
  localparam logic [2:0] MUX_SIGNAL   = 3'h6;
  localparam logic [2:0] MUX_BIAS_POS = 3'h3;
  localparam logic [2:0] MUX_BIAS_NEG = 3'h2;
  localparam logic [2:0] MUX_REF1_NEG = 3'h5;
  localparam logic [2:0] MUX_REF1_POS = 3'h4;
  localparam logic [2:0] MUX_REF2_NEG = 3'h1;
  localparam logic [2:0] MUX_REF2_POS = 3'h0;

  // bias code width and reset value
  localparam int         BIAS_WIDTH = 8;
  localparam logic [7:0] BIAS_RESET = 8'h00;

  // phase lengths in cycles of core_clk
  localparam int PHASE_CYCLES_DEFAULT = 16;
  localparam int PHASE_CNT_WIDTH      = 16;

endpackage

// ### src/rsss_front_end.sv
// module: front-end switch decoder, bias latches and multiplexer follower
`timescale 1ns/1ps
module rsss_front_end
  import rsss_pkg::*;
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  // link from host
  rsss_link_if.device               link,
  // analog switches and relays
  output logic                      high_gain_feedback_tap,
  output logic                      attenuated_output_switch,
  output logic                      direct_output_switch,
  output logic                      unity_feedback_switch,
  output logic                      low_gain_feedback_tap,
  output logic                      input_protect_relay,
  output logic                      filter_relay,
  output logic                      test_inject_switch,
  output logic                      bootstrap_inverter_driver,
  // bias ladder and multiplexer
  output logic [rsss_pkg::BIAS_WIDTH-1:0] binary_ladder,
  output logic [2:0]                input_multiplexer
);
  import rsss_pkg::*;

  // synchronised copies of the host lines
  logic [2:0]  s_range;
  logic        s_dc;
  logic        s_filter;
  logic        s_test;
  logic [7:0]  s_bias;
  logic [2:0]  s_mux;
  logic [2:0]  s_mux_n;
  logic        s_rload;
  logic        s_bload;

  // strobe edges and the request that waits for the reset code
  logic        rload_d;
  logic        bload_d;
  logic        rload_rise;
  logic        bload_rise;
  logic        take_range;
  logic        take_bias;
  logic        pend_valid;
  logic [2:0]  pend_range;
  logic        pend_dc;
  logic        pend_filter;
  logic        pend_test;
  logic        mux_at_reset;
  logic        apply_now;

  // range decode, switch pattern and bias latches
  logic        sel_100mv;
  logic        sel_1v;
  logic        sel_10v;
  logic        sel_100v;
  logic [5:0]  range_pattern;
  logic [5:0]  test_pattern;
  logic [5:0]  next_pattern;
  logic [5:0]  pattern;
  logic [3:0]  bias_code_latch_low;
  logic [3:0]  bias_code_latch_high;

  // --------------------------------------------------------------
  // isolated lines enter through two flops each
  // --------------------------------------------------------------
  // the select lines pass inverted: the flops clear to zero, and the
  // multiplexer must see the reset code, not a reference code, after reset
  rsss_sync #(.WIDTH(19)) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in ({link.range_code, link.func_dc, link.filter_sel, link.test_sel,
                link.bias_data, ~link.mux_sel, link.range_load, link.bias_load}),
    .sync_out ({s_range, s_dc, s_filter, s_test, s_bias, s_mux_n, s_rload, s_bload})
  );
  assign s_mux = ~s_mux_n;

  // load strobes are edges so a stretched pulse acts once; the lines that a
  // strobe qualifies are taken a cycle after its edge, since each line has
  // its own flops and may resolve a cycle after the strobe does
  assign rload_rise   = s_rload & ~rload_d;
  assign bload_rise   = s_bload & ~bload_d;
  assign mux_at_reset = (s_mux == MUX_RESET);
  assign apply_now    = pend_valid & mux_at_reset;

  // --------------------------------------------------------------
  // range decode
  // --------------------------------------------------------------
  // one select per range below 1000V; 1000V and any code outside the table select none
  assign sel_100mv = (pend_range == RANGE_100MV);
  assign sel_1v    = (pend_range == RANGE_1V);
  assign sel_10v   = (pend_range == RANGE_10V);
  assign sel_100v  = (pend_range == RANGE_100V);

  // the top two ranges reuse the 1V and 10V amplifier settings with the
  // relay released; an unknown code falls to 1000V, the safest setting
  assign range_pattern = sel_100mv ? PAT_100MV :
                         sel_1v    ? PAT_1V    :
                         sel_10v   ? PAT_10V   :
                         sel_100v  ? PAT_100V  :
                                     PAT_1000V;

  // self-test drops the protect relay, the top bit, so the attenuator sits
  // across the input while the amplifier keeps the chosen range's setting
  assign test_pattern = {1'b0, range_pattern[SW_PROTECT-1:0]};
  assign next_pattern = pend_test ? test_pattern : range_pattern;

  // --------------------------------------------------------------
  // capture request, apply only at multiplexer reset
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rload_d     <= 1'b0;
      bload_d     <= 1'b0;
      take_range  <= 1'b0;
      take_bias   <= 1'b0;
      pend_valid  <= 1'b0;
      pend_range  <= RANGE_1000V;
      pend_dc     <= 1'b1;
      pend_filter <= 1'b0;
      pend_test   <= 1'b0;
    end else begin
      rload_d    <= s_rload;
      bload_d    <= s_bload;
      take_range <= rload_rise;
      take_bias  <= bload_rise;
      // a new request wins over the clear, so none is ever dropped
      if (take_range) begin
        pend_valid  <= 1'b1;
        pend_range  <= s_range;
        pend_dc     <= s_dc;
        pend_filter <= s_filter;
        pend_test   <= s_test;
      end else if (apply_now) begin
        pend_valid <= 1'b0;
      end
    end
  end

  // switch outputs held through a conversion; reset lands on 1000V DC,
  // so an unconfigured input always sees the attenuator first
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pattern                   <= PAT_1000V;
      filter_relay              <= 1'b0;
      test_inject_switch        <= 1'b0;
      bootstrap_inverter_driver <= 1'b1;
    end else if (apply_now) begin
      pattern                   <= next_pattern;
      filter_relay              <= pend_filter | pend_test;
      test_inject_switch        <= pend_test;
      bootstrap_inverter_driver <= pend_dc;
    end
  end

  // each switch and the protect relay is one bit of the held pattern
  assign high_gain_feedback_tap   = pattern[SW_HIGH_GAIN];
  assign attenuated_output_switch = pattern[SW_ATTEN_OUT];
  assign direct_output_switch     = pattern[SW_DIRECT];
  assign unity_feedback_switch    = pattern[SW_UNITY];
  assign low_gain_feedback_tap    = pattern[SW_LOW_GAIN];
  assign input_protect_relay      = pattern[SW_PROTECT];

  // --------------------------------------------------------------
  // bias-compensation latches, two nibbles feeding the ladder
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bias_code_latch_low  <= BIAS_RESET[3:0];
      bias_code_latch_high <= BIAS_RESET[7:4];
    end else if (take_bias) begin
      bias_code_latch_low  <= s_bias[3:0];
      bias_code_latch_high <= s_bias[7:4];
    end
  end

  // the high latch carries the upper nibble of the ladder code
  assign binary_ladder = {bias_code_latch_high, bias_code_latch_low};

  // multiplexer follows host lines; reset code on reset
  // each code reaches the multiplexer three cycles after the host sets it,
  // so the host must keep every phase longer than that
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      input_multiplexer <= MUX_RESET;
    end else begin
      input_multiplexer <= s_mux;
    end
  end
endmodule

// ### src/rsss_host.sv
// module: host-side controller that drives the isolated lines and phase timing
`timescale 1ns/1ps
module rsss_host
  import rsss_pkg::*;
#(
  parameter int PHASE_CYCLES = rsss_pkg::PHASE_CYCLES_DEFAULT
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // user side: settings
  input  wire logic [2:0] range_sel,
  input  wire logic       dc_sel,
  input  wire logic       filter_sel,
  input  wire logic       test_sel,
  input  wire logic [7:0] stored_zero,
  // user side: conversion
  input  wire logic       start,
  input  wire logic       negative,
  output logic            busy,
  output logic            done,
  // link to front end
  rsss_link_if.host       link
);
  import rsss_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_SIGNAL, ST_BIAS, ST_REF1, ST_REF2
  } rsss_state_type;

  rsss_state_type state;
  logic [PHASE_CNT_WIDTH-1:0] count;
  logic neg_q;
  logic phase_end;

  assign phase_end = (count == PHASE_CNT_WIDTH'(PHASE_CYCLES - 1));
  assign busy      = (state != ST_IDLE);

  // ------------------------------------------------------------
  // sequence: setup in reset, then signal, bias, ref1, ref2
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state           <= ST_IDLE;
      count           <= '0;
      neg_q           <= 1'b0;
      done            <= 1'b0;
      link.mux_sel    <= MUX_RESET;
      link.range_code <= RANGE_1000V;
      link.func_dc    <= 1'b1;
      link.filter_sel <= 1'b0;
      link.test_sel   <= 1'b0;
      link.bias_data  <= BIAS_RESET;
      link.range_load <= 1'b0;
      link.bias_load  <= 1'b0;
    end else begin
      done  <= 1'b0;
      count <= phase_end ? '0 : count + 1'b1;
      unique case (state)
        ST_IDLE: begin
          count <= '0;
          link.mux_sel <= MUX_RESET;
          if (start) begin
            neg_q           <= negative;
            link.range_code <= range_sel;
            link.func_dc    <= dc_sel;
            link.filter_sel <= filter_sel;
            link.test_sel   <= test_sel;
            link.bias_data  <= stored_zero;
            link.range_load <= 1'b1;
            link.bias_load  <= dc_sel;
            state           <= ST_SETUP;
          end
        end
        ST_SETUP: if (phase_end) begin
          link.range_load <= 1'b0;
          link.bias_load  <= 1'b0;
          link.mux_sel    <= MUX_SIGNAL;
          state           <= ST_SIGNAL;
        end
        ST_SIGNAL: if (phase_end) begin
          link.mux_sel <= neg_q ? MUX_BIAS_NEG : MUX_BIAS_POS;
          state        <= ST_BIAS;
        end
        ST_BIAS: if (phase_end) begin
          link.mux_sel <= neg_q ? MUX_REF1_POS : MUX_REF1_NEG;
          state        <= ST_REF1;
        end
        ST_REF1: if (phase_end) begin
          link.mux_sel <= neg_q ? MUX_REF2_POS : MUX_REF2_NEG;
          state        <= ST_REF2;
        end
        ST_REF2: if (phase_end) begin
          link.mux_sel <= MUX_RESET;
          done         <= 1'b1;
          state        <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ### src/rsss_sync.sv
// module: two-flop synchroniser for a bus of isolated lines
`timescale 1ns/1ps
module rsss_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  // lines
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // first stage read only by the second
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// ### verification/range_switch_and_slope_sequencer_tb.sv
// testbench: host and front end joined by the link, switch outputs checked
`timescale 1ns/1ps
module range_switch_and_slope_sequencer_tb;
  import rsss_pkg::*;
  // one case: inputs, then pattern {protect, low, unity, direct, atten, high}
  typedef struct packed {
    logic [2:0] rng;
    logic       dc;
    logic       flt;
    logic       tst;
    logic       neg;
    logic [7:0] zero;
    logic [5:0] pat;
  } rsss_row_type;
  localparam int ROWS = 9;
  localparam rsss_row_type TABLE [ROWS] = '{
    '{3'h0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h3C, 6'h25},
    '{3'h1, 1'b1, 1'b1, 1'b0, 1'b1, 8'hA5, 6'h34},
    '{3'h2, 1'b0, 1'b0, 1'b0, 1'b0, 8'hFF, 6'h2A},
    '{3'h3, 1'b1, 1'b1, 1'b0, 1'b1, 8'h0F, 6'h14},
    '{3'h4, 1'b1, 1'b0, 1'b0, 1'b0, 8'hF0, 6'h0A},
    '{3'h0, 1'b1, 1'b0, 1'b1, 1'b0, 8'h81, 6'h25},
    '{3'h1, 1'b1, 1'b0, 1'b1, 1'b1, 8'h7E, 6'h34},
    '{3'h2, 1'b1, 1'b0, 1'b1, 1'b0, 8'h01, 6'h2A},
    '{3'h5, 1'b1, 1'b0, 1'b0, 1'b1, 8'h55, 6'h0A}};
  // user side and observed outputs
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] range_sel = 3'h0;
  logic dc_sel = 1'b0;
  logic filter_sel = 1'b0;
  logic test_sel = 1'b0;
  logic start = 1'b0;
  logic negative = 1'b0;
  logic [7:0] stored_zero = 8'h00;
  logic done, high_gain_feedback_tap, attenuated_output_switch, direct_output_switch;
  logic unity_feedback_switch, low_gain_feedback_tap, input_protect_relay, filter_relay;
  logic test_inject_switch, bootstrap_inverter_driver, busy;
  logic seq_clr = 1'b0;
  logic [7:0] binary_ladder, zero_q;
  logic [2:0] input_multiplexer, mux_q;
  logic [14:0] seq;
  logic [5:0] pat_q;
  int error_cnt = 0;
  int check_count = 0;
  wire [5:0] pat = {input_protect_relay, low_gain_feedback_tap, unity_feedback_switch,
                    direct_output_switch, attenuated_output_switch, high_gain_feedback_tap};
  always #2.5 core_clk = ~core_clk;
  rsss_link_if link ();
  // six-cycle phases clear the three-cycle crossing with margin
  rsss_host #(.PHASE_CYCLES(6)) rsss_host_inst (.core_clk, .reset_n, .range_sel, .dc_sel,
    .filter_sel, .test_sel, .stored_zero, .start, .negative, .busy, .done, .link(link));
  rsss_front_end rsss_front_end_inst (.core_clk, .reset_n, .link(link),
    .high_gain_feedback_tap, .attenuated_output_switch, .direct_output_switch,
    .unity_feedback_switch, .low_gain_feedback_tap, .input_protect_relay, .filter_relay,
    .test_inject_switch, .bootstrap_inverter_driver, .binary_ladder, .input_multiplexer);
  rsss_link_props rsss_link_props_inst (.core_clk, .reset_n, .range_load(link.range_load),
    .func_dc(link.func_dc), .bias_load(link.bias_load), .mux_sel(link.mux_sel));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // log each new multiplexer code; the pattern must not move mid-conversion
  always @(posedge core_clk) begin
    if (seq_clr) seq <= 15'h0000;
    else if (input_multiplexer !== mux_q) seq <= {seq[11:0], input_multiplexer};
    mux_q <= input_multiplexer;
    if (reset_n && input_multiplexer !== 3'h7) check("hold", 16'(pat), 16'(pat_q));
    pat_q <= pat;
  end
  task automatic rst_chk;
    // the select lines must rest in the reset code from the first cycle on
    repeat (4) begin
      @(negedge core_clk);
      check("rst mux early", 16'(input_multiplexer), 16'h0007);
    end
    check("rst pattern", 16'(pat), 16'h000A);
    check("rst filter", 16'(filter_relay), 16'h0000);
    check("rst inject", 16'(test_inject_switch), 16'h0000);
    check("rst boot", 16'(bootstrap_inverter_driver), 16'h0001);
    check("rst ladder", 16'(binary_ladder), 16'h0000);
    check("rst mux", 16'(input_multiplexer), 16'h0007);
    zero_q = 8'h00;
  endtask
  task automatic run(input int i);
    rsss_row_type r;
    int n;
    r = TABLE[i];
    @(posedge core_clk);
    range_sel <= r.rng;
    dc_sel <= r.dc;
    filter_sel <= r.flt;
    test_sel <= r.tst;
    negative <= r.neg;
    stored_zero <= r.zero;
    start <= 1'b1;
    seq_clr <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    seq_clr <= 1'b0;
    @(negedge core_clk);
    check("busy", 16'(busy), 16'h0001);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (done !== 1'b1 && n < 400);
    check("done", 16'(n < 400), 16'h0001);
    // the multiplexer view lags by three cycles
    repeat (8) @(posedge core_clk);
    if (r.dc) zero_q = r.zero;
    check("pattern", 16'(pat), 16'(r.tst ? r.pat & 6'h1F : r.pat));
    check("filter", 16'(filter_relay), 16'(r.flt | r.tst));
    check("inject", 16'(test_inject_switch), 16'(r.tst));
    check("boot", 16'(bootstrap_inverter_driver), 16'(r.dc));
    check("ladder", 16'(binary_ladder), 16'(zero_q));
    check("walk", 16'(seq), r.neg ? 16'h6507 : 16'h674F);
    check("rest", 16'(input_multiplexer), 16'h0007);
    check("idle", 16'(busy), 16'h0000);
    $display("row %0d finished", i);
  endtask
  // a conversion takes about thirty cycles; the limit leaves wide margin
  initial begin
    #20000;
    error_cnt++;
    $display("watchdog expired");
    wrap_up;
  end
  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    rst_chk;
    $display("reset test finished");
    for (int i = 0; i < ROWS; i++) begin
      run(i);
    end
    // reset in mid-conversion, then a clean conversion again
    @(posedge core_clk);
    range_sel <= 3'h0;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    rst_chk;
    $display("mid-run reset test finished");
    run(0);
    wrap_up;
  end
endmodule

// ### verification/rsss_link_props.sv
// checker: multiplexer walk and load timing on the isolated link
`timescale 1ns/1ps
module rsss_link_props (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       reset_n,
  // link lines
  input wire logic       range_load,
  input wire logic       func_dc,
  input wire logic       bias_load,
  input wire logic [2:0] mux_sel
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // --------------------------------
  // phase order of each conversion
  // --------------------------------
  a_reset_to_signal: assert property (
    $changed(mux_sel) && $past(mux_sel) == 3'h7 |-> mux_sel == 3'h6)
    else $error("reset not followed by signal");
  a_signal_to_bias: assert property (
    $changed(mux_sel) && $past(mux_sel) == 3'h6 |-> mux_sel inside {3'h3, 3'h2})
    else $error("signal not followed by bias");
  a_pos_coarse: assert property (
    $changed(mux_sel) && $past(mux_sel) == 3'h3 |-> mux_sel == 3'h5)
    else $error("positive bias not followed by coarse ref");
  a_pos_fine: assert property (
    $changed(mux_sel) && $past(mux_sel) == 3'h5 |-> mux_sel == 3'h1)
    else $error("coarse ref not followed by fine ref");
  a_neg_coarse: assert property (
    $changed(mux_sel) && $past(mux_sel) == 3'h2 |-> mux_sel == 3'h4)
    else $error("negative bias not followed by coarse ref");
  a_neg_fine: assert property (
    $changed(mux_sel) && $past(mux_sel) == 3'h4 |-> mux_sel == 3'h0)
    else $error("coarse ref not followed by fine ref");
  a_fine_to_reset: assert property (
    $changed(mux_sel) && $past(mux_sel) inside {3'h0, 3'h1} |-> mux_sel == 3'h7)
    else $error("fine ref not followed by reset");
  // a phase lasts at least four cycles, so the far end sees every code
  a_phase_hold: assert property (
    $changed(mux_sel) |=> $stable(mux_sel)[*3])
    else $error("multiplexer phase too short");
  // --------------------------------
  // range load only while at rest, bias load only with dc
  // --------------------------------
  a_load_in_reset: assert property (
    range_load |-> mux_sel == 3'h7)
    else $error("range load outside reset code");
  a_bias_on_dc: assert property (
    bias_load |-> func_dc)
    else $error("bias load without dc");
  c_pos_walk: cover property (mux_sel == 3'h3);
  c_neg_walk: cover property (mux_sel == 3'h2);
  c_range_load: cover property ($rose(range_load));
endmodule
